// ==== src/tbsid_pkg.sv ====
// Purpose: constants and carriers for the trace buffer status/id register bank
// Assumes: ahb-lite slave, 32-bit data, one aligned word per register
// Notes:   offsets are local choices; values fixed in hardware
package tbsid_pkg;

   // register byte offsets
   localparam logic [11:0] OFS_LOCK_KEY   = 12'hfb0;
   localparam logic [11:0] OFS_LOCK_STAT  = 12'hfb4;
   localparam logic [11:0] OFS_AUTH_STAT  = 12'hfb8;
   localparam logic [11:0] OFS_DEV_CAPS   = 12'hfc8;
   localparam logic [11:0] OFS_DEV_TYPE   = 12'hfcc;
   localparam logic [11:0] OFS_SCRATCH    = 12'hf00;
   localparam int          ADDR_LSB       = 2;
   localparam int          ADDR_W         = 12;

   // top bits of the fixed fields, lowest bit is always bit 0
   localparam int          AUTH_MSB       = 7;
   localparam int          MUX_MSB        = 4;
   localparam int          TYPE_MSB       = 7;

   // lock key and field positions
   localparam logic [31:0] LOCK_KEY_OPEN  = 32'hc5acce55;
   localparam int          BIT_SIZE_FLAG  = 2;
   localparam int          BIT_ENGAGED    = 1;
   localparam int          BIT_PRESENT    = 0;
   localparam int          BIT_RAM_CLK    = 5;

   // fixed field values
   localparam logic [1:0]  AUTH_LEVEL_NONE = 2'h0;
   localparam logic [4:0]  MUX_COUNT_NONE  = 5'h00;
   localparam logic        RAM_CLK_SYNC    = 1'h0;
   localparam logic        SIZE_FLAG_32    = 1'h0;
   localparam logic [3:0]  TYPE_SUB_TBUF   = 4'h1;   // arbitrary
   localparam logic [3:0]  TYPE_MAJ_SINK   = 4'h2;   // arbitrary
   localparam logic        LOCK_RESET      = 1'h1;
   localparam logic [31:0] SCRATCH_RESET   = 32'h0;
   localparam logic [31:0] WORD_ZERO       = 32'h0;
   localparam logic        FLAG_RESET      = 1'h0;
   localparam logic        HREADY_ON       = 1'h1;
   localparam logic        HRESP_OKAY      = 1'h0;

   // ahb encodings
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ     = 2'h3;
   localparam logic [2:0]  HSIZE_WORD     = 3'h2;

   typedef struct packed {
      logic [1:0] secure_noninvasive_level;
      logic [1:0] secure_invasive_level;
      logic [1:0] nonsecure_noninvasive_level;
      logic [1:0] nonsecure_invasive_level;
   } tbsid_auth_t;

   // one-hot word select, decoded from an address
   typedef struct packed {
      logic lock_key;
      logic lock_stat;
      logic auth_stat;
      logic dev_caps;
      logic dev_type;
      logic scratch;
   } tbsid_sel_t;

   typedef struct packed {
      logic             valid;
      logic             write;
      logic             ext_dbg;
      logic [ADDR_W-1:0] addr;
   } tbsid_req_t;

endpackage

// ==== src/tbsid_lock.sv ====
// Purpose: software lock state for the on-chip interface
// Assumes: write strobe is one cycle, data valid with it
// Notes:   debugger writes never touch the lock
`timescale 1ns/1ps
`default_nettype none
module tbsid_lock #(
   parameter bit LOCK_IMPL = 1'b1
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // key write
   input  wire logic        key_wr,
   input  wire logic        key_ext,
   input  wire logic [31:0] key_data,
   // state
   output logic             engaged_r
);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         engaged_r <= LOCK_IMPL ? tbsid_pkg::LOCK_RESET : 1'b0;
      end else if (LOCK_IMPL && key_wr && !key_ext) begin
         engaged_r <= (key_data != tbsid_pkg::LOCK_KEY_OPEN);
      end
   end

endmodule
`default_nettype wire

// ==== src/tbsid_regs.sv ====
// Purpose: trace buffer status and identification registers on ahb-lite
// Assumes: single word transfers; hreadyout always high; always OKAY
// Notes:   ext_dbg marks accesses from the external debugger port
`timescale 1ns/1ps
`default_nettype none
module tbsid_regs #(
   parameter bit LOCK_IMPL = 1'b1
) (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // access origin, same clock domain
   input  wire logic        ext_dbg,
   // status
   output logic             lock_engaged_flag
);


   ////////////////////////////////////////////////////////////////////////
   // elaboration checks

   // the decode drops the byte lane bits, so a word must fit the window
   if (tbsid_pkg::ADDR_W <= tbsid_pkg::ADDR_LSB) begin : g_bad_window
      $error("address window narrower than one word");
   end

   // a misaligned offset would alias its neighbour in the word decode
   if (tbsid_pkg::OFS_LOCK_KEY[tbsid_pkg::ADDR_LSB-1:0] != '0
       || tbsid_pkg::OFS_LOCK_STAT[tbsid_pkg::ADDR_LSB-1:0] != '0
       || tbsid_pkg::OFS_AUTH_STAT[tbsid_pkg::ADDR_LSB-1:0] != '0
       || tbsid_pkg::OFS_DEV_CAPS[tbsid_pkg::ADDR_LSB-1:0] != '0
       || tbsid_pkg::OFS_DEV_TYPE[tbsid_pkg::ADDR_LSB-1:0] != '0
       || tbsid_pkg::OFS_SCRATCH[tbsid_pkg::ADDR_LSB-1:0] != '0) begin : g_bad_offset
      $error("register offset not word aligned");
   end

   // fixed fields must fill exactly the bits reserved for them
   if ($bits(tbsid_pkg::tbsid_auth_t) != tbsid_pkg::AUTH_MSB + 1) begin : g_bad_auth
      $error("authentication field width does not match its slot");
   end

   if ($bits(tbsid_pkg::MUX_COUNT_NONE) != tbsid_pkg::MUX_MSB + 1) begin : g_bad_mux
      $error("multiplexing count width does not match its slot");
   end

   if ($bits({tbsid_pkg::TYPE_SUB_TBUF, tbsid_pkg::TYPE_MAJ_SINK})
       != tbsid_pkg::TYPE_MSB + 1) begin : g_bad_type
      $error("device type width does not match its slot");
   end

   // the capability flag must sit above the multiplexing count
   if (tbsid_pkg::BIT_RAM_CLK <= tbsid_pkg::MUX_MSB) begin : g_bad_caps
      $error("capability flag overlaps the multiplexing count");
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic is_start(input logic [1:0] trans);
      is_start = (trans == tbsid_pkg::HTRANS_NONSEQ)
                 || (trans == tbsid_pkg::HTRANS_SEQ);
   endfunction

   function automatic logic hit(input logic [tbsid_pkg::ADDR_W-1:0] a,
                                input logic [tbsid_pkg::ADDR_W-1:0] ofs);
      hit = (a[tbsid_pkg::ADDR_W-1:tbsid_pkg::ADDR_LSB]
             == ofs[tbsid_pkg::ADDR_W-1:tbsid_pkg::ADDR_LSB]);
   endfunction

   // used for the address phase (reads) and the data phase (writes)
   function automatic tbsid_pkg::tbsid_sel_t decode(input logic [tbsid_pkg::ADDR_W-1:0] a);
      decode           = '0;
      decode.lock_key  = hit(a, tbsid_pkg::OFS_LOCK_KEY);
      decode.lock_stat = hit(a, tbsid_pkg::OFS_LOCK_STAT);
      decode.auth_stat = hit(a, tbsid_pkg::OFS_AUTH_STAT);
      decode.dev_caps  = hit(a, tbsid_pkg::OFS_DEV_CAPS);
      decode.dev_type  = hit(a, tbsid_pkg::OFS_DEV_TYPE);
      decode.scratch   = hit(a, tbsid_pkg::OFS_SCRATCH);
   endfunction

   // any key but the open value engages the lock
   function automatic logic key_locks(input logic [31:0] key);
      key_locks = (key != tbsid_pkg::LOCK_KEY_OPEN);
   endfunction

   function automatic logic [31:0] lock_status_word(input logic locked,
                                                    input logic present);
      lock_status_word                           = tbsid_pkg::WORD_ZERO;
      lock_status_word[tbsid_pkg::BIT_SIZE_FLAG] = tbsid_pkg::SIZE_FLAG_32;
      lock_status_word[tbsid_pkg::BIT_ENGAGED]   = locked;
      lock_status_word[tbsid_pkg::BIT_PRESENT]   = present;
   endfunction

   function automatic logic [31:0] auth_word();
      tbsid_pkg::tbsid_auth_t levels;
      levels                           = '{default: tbsid_pkg::AUTH_LEVEL_NONE};
      auth_word                        = tbsid_pkg::WORD_ZERO;
      auth_word[tbsid_pkg::AUTH_MSB:0] = levels;
   endfunction

   function automatic logic [31:0] caps_word();
      caps_word                         = tbsid_pkg::WORD_ZERO;
      caps_word[tbsid_pkg::BIT_RAM_CLK] = tbsid_pkg::RAM_CLK_SYNC;
      caps_word[tbsid_pkg::MUX_MSB:0]   = tbsid_pkg::MUX_COUNT_NONE;
   endfunction

   function automatic logic [31:0] type_word();
      type_word                        = tbsid_pkg::WORD_ZERO;
      type_word[tbsid_pkg::TYPE_MSB:0] = {tbsid_pkg::TYPE_SUB_TBUF,
                                          tbsid_pkg::TYPE_MAJ_SINK};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // signals

   tbsid_pkg::tbsid_req_t        req_r;
   tbsid_pkg::tbsid_sel_t        ap_sel;
   tbsid_pkg::tbsid_sel_t        dp_sel;
   logic                         ap_take;
   logic                         ap_read;
   logic                         ap_own;
   logic [tbsid_pkg::ADDR_W-1:0] ap_addr;
   logic                         dp_write;
   logic                         dp_own;
   logic                         key_wr;
   logic                         key_own;
   logic                         engaged;
   logic                         engaged_view;
   logic                         scratch_wr;
   logic [31:0]                  scratch_r;
   logic [31:0]                  rd_nxt;

   ////////////////////////////////////////////////////////////////////////
   // address phase

   assign ap_take = hsel && hready && is_start(htrans);
   assign ap_read = ap_take && !hwrite;
   assign ap_own  = !ext_dbg;
   assign ap_addr = haddr[tbsid_pkg::ADDR_W-1:0];
   assign ap_sel  = decode(ap_addr);

   // the request is kept for its data phase, where write data arrives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_r <= '0;
      end else if (hready) begin
         req_r.valid   <= ap_take;
         req_r.write   <= hwrite;
         req_r.ext_dbg <= ext_dbg;
         req_r.addr    <= ap_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data phase

   assign dp_write = req_r.valid && req_r.write;
   assign dp_own   = !req_r.ext_dbg;
   assign dp_sel   = decode(req_r.addr);
   assign key_wr   = dp_write && dp_sel.lock_key;
   assign key_own  = LOCK_IMPL && key_wr && dp_own;

   // the debugger bypasses the lock; status words take no writes at all
   assign scratch_wr = dp_write && dp_sel.scratch && !(engaged && dp_own);

   ////////////////////////////////////////////////////////////////////////
   // lock

   tbsid_lock #(
      .LOCK_IMPL (LOCK_IMPL)
   ) u_lock (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .key_wr    (key_wr),
      .key_ext   (req_r.ext_dbg),
      .key_data  (hwdata),
      .engaged_r (engaged)
   );

   // a key write in this data phase is shown to a read taken at the same edge,
   // so a back to back read after the key sees the new state
   assign engaged_view = key_own ? key_locks(hwdata) : engaged;

   ////////////////////////////////////////////////////////////////////////
   // scratch word, the only read/write word; it makes the lock observable

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scratch_r <= tbsid_pkg::SCRATCH_RESET;
      end else if (scratch_wr) begin
         scratch_r <= hwdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read select, decided in the address phase

   always_comb begin
      rd_nxt = tbsid_pkg::WORD_ZERO;
      if (ap_sel.lock_stat) begin
         if (ap_own) begin
            rd_nxt = lock_status_word(engaged_view, LOCK_IMPL);
         end
      end else if (ap_sel.auth_stat) begin
         rd_nxt = auth_word();
      end else if (ap_sel.dev_caps) begin
         rd_nxt = caps_word();
      end else if (ap_sel.dev_type) begin
         rd_nxt = type_word();
      end else if (ap_sel.scratch) begin
         // forward a write landing at the same edge, else the read goes stale
         rd_nxt = scratch_wr ? hwdata : scratch_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, each straight from its own flip-flop

   // read data stands until the next read is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= tbsid_pkg::WORD_ZERO;
      end else if (ap_read) begin
         hrdata <= rd_nxt;
      end
   end

   // zero wait states: nothing here ever needs a second cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= tbsid_pkg::HREADY_ON;
      end else begin
         hreadyout <= tbsid_pkg::HREADY_ON;
      end
   end

   // refused writes are dropped silently, never flagged as errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= tbsid_pkg::HRESP_OKAY;
      end else begin
         hresp <= tbsid_pkg::HRESP_OKAY;
      end
   end

   // one cycle behind the internal lock state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_engaged_flag <= tbsid_pkg::FLAG_RESET;
      end else begin
         lock_engaged_flag <= engaged;
      end
   end

endmodule
`default_nettype wire

// ==== test/tbsid_regs_chk.sv ====
// Purpose: port assertions for the status and id register bank
// Assumes: zero-wait slave, read data in the cycle after its address phase
// Notes:   key write is judged in its data phase
`timescale 1ns/1ps
`default_nettype none
module tbsid_regs_chk #(parameter bit LOCK_IMPL = 1'b1) (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // bus
   input wire logic        hsel,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        ext_dbg,
   input wire logic [31:0] haddr,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic [1:0]  htrans,
   // status
   input wire logic        lock_engaged_flag
);
   logic        rd_q, wr_q, x_q;
   logic [11:0] a_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {rd_q, wr_q, x_q, a_q} <= '0;
      end else begin
         {rd_q, wr_q} <= {2{hsel & hready & htrans[1]}} & {!hwrite, hwrite};
         {x_q, a_q} <= {ext_dbg, haddr[11:0]};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire lstat = rd_q && a_q == tbsid_pkg::OFS_LOCK_STAT;
   wire cap = rd_q && a_q == tbsid_pkg::OFS_DEV_CAPS;
   lock_size_a: assert property (lstat && !x_q |-> hrdata[31:2] == '0)
      else $error("lock status size bit");
   // the read shows the state after any key write landing with it; the flag lags one cycle
   lock_state_a: assert property (lstat && !x_q |=> lock_engaged_flag == $past(hrdata[1]))
      else $error("lock status state bit");
   lock_present_a: assert property (lstat && !x_q |-> hrdata[0] == LOCK_IMPL)
      else $error("lock status present bit");
   lock_dbg_a: assert property (lstat && x_q |-> hrdata == '0)
      else $error("debugger lock status");
   auth_zero_a: assert property (rd_q && a_q == tbsid_pkg::OFS_AUTH_STAT |-> !hrdata)
      else $error("auth status");
   caps_ram_a: assert property (cap |-> hrdata[31:5] == '0)
      else $error("caps ram bit");
   caps_mux_a: assert property (cap |-> hrdata[4:0] == tbsid_pkg::MUX_COUNT_NONE)
      else $error("caps mux count");
   type_fixed_a: assert property (rd_q && a_q == tbsid_pkg::OFS_DEV_TYPE |->
      hrdata == {24'h0, tbsid_pkg::TYPE_SUB_TBUF, tbsid_pkg::TYPE_MAJ_SINK})
      else $error("device type");
   key_open_a: assert property (wr_q && !x_q && a_q == tbsid_pkg::OFS_LOCK_KEY &&
      hwdata == tbsid_pkg::LOCK_KEY_OPEN |-> ##[1:2] !lock_engaged_flag)
      else $error("unlock key ignored");
endmodule
bind tbsid_regs tbsid_regs_chk #(.LOCK_IMPL(LOCK_IMPL)) tbsid_regs_chk_i (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready), .ext_dbg(ext_dbg),
   .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans),
   .lock_engaged_flag(lock_engaged_flag));
`default_nettype wire

// ==== test/tbsid_regs_test.sv ====
// Purpose: random bus traffic checked against a bench model
// Assumes: zero-wait slave; lock engaged after reset
// Notes:   key reads skipped, the key word is write only
`timescale 1ns/1ps
`default_nettype none
module tbsid_regs_test;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_dbg = 0, w, x;
   logic        hreadyout, hresp, lock_engaged_flag;
   logic [1:0]  htrans = '0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q, d;
   logic [11:0] a;
   logic [11:0] map [7] = '{tbsid_pkg::OFS_LOCK_KEY, tbsid_pkg::OFS_LOCK_STAT,
      tbsid_pkg::OFS_AUTH_STAT, tbsid_pkg::OFS_DEV_CAPS, tbsid_pkg::OFS_DEV_TYPE,
      tbsid_pkg::OFS_SCRATCH, 12'h004};
   int          fail_count = 0, num_checks = 0, seed = 32'h621c, lk, sc;
   always #12.5 hclk = ~hclk;
   tbsid_regs tbsid_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(tbsid_pkg::HSIZE_WORD), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ext_dbg(ext_dbg), .lock_engaged_flag(lock_engaged_flag));
   task chk(string n, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task results;
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // one single transfer; each phase waits on hready, then two fixed negedges to settle
   task bus;
      @(posedge hclk);
      {hsel, hwrite, ext_dbg} <= {1'b1, w, x};
      htrans <= tbsid_pkg::HTRANS_NONSEQ;
      haddr <= {20'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      {hsel, htrans, hwdata} <= {3'h0, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      repeat (2) @(negedge hclk);
   endtask
   // id and auth words read fixed, lock status and scratch follow the model; debugger sees lock status as zero
   function logic [31:0] expv;
      case (a)
         tbsid_pkg::OFS_LOCK_STAT: expv = x ? '0 : {30'h0, lk[0], 1'b1};
         tbsid_pkg::OFS_DEV_TYPE: expv = {24'h0, tbsid_pkg::TYPE_SUB_TBUF,
            tbsid_pkg::TYPE_MAJ_SINK};
         tbsid_pkg::OFS_SCRATCH: expv = sc;
         default: expv = '0;
      endcase
   endfunction
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      {lk, sc} = {32'd1, 32'd0};
      for (int i = 0; i < 300; i++) begin
         if (i == 150) begin
            @(posedge hclk);
            hresetn <= 0;
            repeat (2) @(posedge hclk);
            hresetn <= 1;
            {lk, sc} = {32'd1, 32'd0};
         end
         a = map[$unsigned($random(seed)) % 7];
         {w, x} = 2'($random(seed));
         d = (($random(seed) & 3) == 0) ? tbsid_pkg::LOCK_KEY_OPEN : 32'($random(seed));
         if (a == tbsid_pkg::OFS_LOCK_KEY) w = 1;
         bus;
         if (!w) chk("read", q, expv());
         else if (a == tbsid_pkg::OFS_LOCK_KEY && !x) lk = d != tbsid_pkg::LOCK_KEY_OPEN;
         else if (a == tbsid_pkg::OFS_SCRATCH && (x || !lk)) sc = d;
         chk("hreadyout hresp", {30'h0, hreadyout, hresp}, 32'h2);
         chk("lock flag", {31'h0, lock_engaged_flag}, 32'(lk));
      end
      results;
   end
   initial begin
      #100us;
      fail_count++;
      results;
   end
endmodule
`default_nettype wire
